// ===== inc/fsr_params.svh
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH

// register width and value forced by clear or reset
`define FSR_WIDTH        4
`define FSR_CLEAR_WORD   4'h0
`define FSR_CLEAR_LAST_N 1'h1

// serial pair {j, k_n} codes for the first stage
`define FSR_JK_LOW       2'h0
`define FSR_JK_HOLD      2'h1
`define FSR_JK_TOGGLE    2'h2
`define FSR_JK_HIGH      2'h3

// depth of the output word buffer
`define FSR_BUF_DEPTH    2

`endif

// ===== inc/fsr_pkg.sv
`default_nettype none

`include "fsr_params.svh"

package fsr_pkg;
   typedef logic [`FSR_WIDTH-1:0] fsr_word_t;
   // low on the shift/load control loads, high shifts
   typedef enum logic {
      FSR_LOAD,
      FSR_SHIFT
   } fsr_mode_e;
endpackage : fsr_pkg

`default_nettype wire

// ===== logic/fsr_buf2.sv
`timescale 1ns/1ps
`default_nettype none

`include "fsr_params.svh"

// small fifo; empty and full are exact so back-pressure reaches the register
module fsr_buf2 #(
   parameter int WIDTH = `FSR_WIDTH,
   parameter int DEPTH = `FSR_BUF_DEPTH
) (
   input  wire logic             i_clk,
   input  wire logic             i_reset,
   input  wire logic             i_clear_n,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] LAST_PTR  = AW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL_CNT  = CW'(DEPTH);
   localparam logic [CW-1:0] ONE_CNT   = CW'(1);
   localparam logic [AW-1:0] ONE_PTR   = AW'(1);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [CW-1:0]    cnt_ff;
   logic             push;
   logic             pop;

   assign o_in_ready  = (cnt_ff != FULL_CNT);
   assign o_out_valid = (cnt_ff != '0);
   assign o_out_data  = mem_ff[rd_ptr_ff];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   // storage needs no clear; the count decides what is valid
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_clear_n) begin
      if (!i_clear_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff    <= '0;
      end else if (i_reset) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff    <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + ONE_PTR;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + ONE_PTR;
         end
         if (push && !pop) begin
            cnt_ff <= cnt_ff + ONE_CNT;
         end else if (pop && !push) begin
            cnt_ff <= cnt_ff - ONE_CNT;
         end
      end
   end
endmodule : fsr_buf2

`default_nettype wire

// ===== logic/fsr_shift_reg.sv
`timescale 1ns/1ps
`default_nettype none

`include "fsr_params.svh"

// How it works
// - four storage stages, each with its own parallel input and output.
// - clear low forces stages low and inverted last high, no clock needed.
// - control low loads parallel inputs on the rising edge.
// - serial inputs are ignored while loading.
// - control high moves stage0 to 1, 1 to 2, 2 to 3 each taken edge.
// - in shift mode the first stage takes the serial pair.
// - pair acts as j/inverted-k: hold, low, high, or toggle.
// - with clear high and no clock edge every stage keeps its level.
module fsr_shift_reg #(
   parameter int WIDTH = `FSR_WIDTH,
   parameter int DEPTH = `FSR_BUF_DEPTH
) (
   input  wire logic             i_clk,
   input  wire logic             i_reset,
   input  wire logic             i_async_clear_n,
   input  wire logic             i_op_valid,
   output logic                  o_op_ready,
   input  wire logic             i_shift_load,
   input  wire logic             i_serial_j,
   input  wire logic             i_serial_k_n,
   input  wire logic [WIDTH-1:0] i_par_data,
   output logic                  o_stage0_out,
   output logic                  o_stage1_out,
   output logic                  o_stage2_out,
   output logic                  o_stage3_out,
   output logic                  o_stage3_out_n,
   output logic                  o_word_valid,
   input  wire logic             i_word_ready,
   output logic      [WIDTH-1:0] o_word_data
);
   fsr_pkg::fsr_mode_e mode;
   logic [WIDTH-1:0]   stage_ff;
   logic [WIDTH-1:0]   nxt_stage;
   logic               stage_last_n_ff;
   logic               nxt_first;
   logic               take;
   logic               buf_in_ready;

   assign mode = fsr_pkg::fsr_mode_e'(i_shift_load);

   // an edge only counts when the buffer can keep the new word,
   // so a stalled reader never loses a value
   assign take       = i_op_valid & buf_in_ready;
   assign o_op_ready = buf_in_ready;

   always_comb begin
      unique case ({i_serial_j, i_serial_k_n})
         `FSR_JK_LOW:    nxt_first = 1'b0;
         `FSR_JK_HOLD:   nxt_first = stage_ff[0];
         `FSR_JK_TOGGLE: nxt_first = ~stage_ff[0];
         `FSR_JK_HIGH:   nxt_first = 1'b1;
      endcase
   end

   // one next-value mux per stage
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_stage
         if (g == 0) begin : g_first
            always_comb begin
               if (mode == fsr_pkg::FSR_LOAD) begin
                  nxt_stage[g] = i_par_data[g];
               end else begin
                  nxt_stage[g] = nxt_first;
               end
            end
         end else begin : g_rest
            always_comb begin
               if (mode == fsr_pkg::FSR_LOAD) begin
                  nxt_stage[g] = i_par_data[g];
               end else begin
                  nxt_stage[g] = stage_ff[g-1];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_async_clear_n) begin
      if (!i_async_clear_n) begin
         stage_ff <= `FSR_CLEAR_WORD;
      end else if (i_reset) begin
         stage_ff <= `FSR_CLEAR_WORD;
      end else if (take) begin
         stage_ff <= nxt_stage;
      end
   end

   // kept as its own flop so the output is registered yet never lags
   always_ff @(posedge i_clk or negedge i_async_clear_n) begin
      if (!i_async_clear_n) begin
         stage_last_n_ff <= `FSR_CLEAR_LAST_N;
      end else if (i_reset) begin
         stage_last_n_ff <= `FSR_CLEAR_LAST_N;
      end else if (take) begin
         stage_last_n_ff <= ~nxt_stage[WIDTH-1];
      end
   end

   assign o_stage0_out   = stage_ff[0];
   assign o_stage1_out   = stage_ff[1];
   assign o_stage2_out   = stage_ff[2];
   assign o_stage3_out   = stage_ff[WIDTH-1];
   assign o_stage3_out_n = stage_last_n_ff;

   // every register value taken on an edge is also queued as a word
   fsr_buf2 #(
      .WIDTH (WIDTH),
      .DEPTH (DEPTH)
   ) u_buf (
      .i_clk       (i_clk),
      .i_reset     (i_reset),
      .i_clear_n   (i_async_clear_n),
      .i_in_valid  (take),
      .o_in_ready  (buf_in_ready),
      .i_in_data   (nxt_stage),
      .o_out_valid (o_word_valid),
      .i_out_ready (i_word_ready),
      .o_out_data  (o_word_data)
   );
endmodule : fsr_shift_reg

`default_nettype wire

// ===== tb/fsr_shift_reg_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fsr_shift_reg_checker (
   input wire logic       i_clk,
   input wire logic       i_reset,
   input wire logic       i_async_clear_n,
   input wire logic       i_op_valid,
   input wire logic       o_op_ready,
   input wire logic       i_shift_load,
   input wire logic       i_serial_j,
   input wire logic       i_serial_k_n,
   input wire logic [3:0] i_par_data,
   input wire logic       o_stage0_out,
   input wire logic       o_stage1_out,
   input wire logic       o_stage2_out,
   input wire logic       o_stage3_out,
   input wire logic       o_stage3_out_n
);
   wire [3:0] q = {o_stage3_out, o_stage2_out, o_stage1_out, o_stage0_out};
   // clear or reset blocks an action, so neither edge may count as taken
   wire run = i_async_clear_n & !i_reset;
   wire tk = run & i_op_valid & o_op_ready;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   chk_clear_forces: assert property (!i_async_clear_n |-> q == 4'h0 && o_stage3_out_n)
      else $error("clear missed");
   chk_clear_ready: assert property (!i_async_clear_n |-> o_op_ready)
      else $error("clear kept words");
   chk_load_data: assert property (i_async_clear_n && $past(tk && !i_shift_load) |->
      q == $past(i_par_data)) else $error("bad load");
   chk_shift_moves: assert property (i_async_clear_n && $past(tk && i_shift_load) |->
      q[3:1] == $past(q[2:0])) else $error("bad shift");
   chk_first_jk: assert property (i_async_clear_n && $past(tk && i_shift_load) |->
      q[0] == $past(i_serial_j & !q[0] | i_serial_k_n & q[0])) else $error("bad first stage");
   chk_idle_holds: assert property (i_async_clear_n && $past(run && !tk) |-> $stable(q))
      else $error("stages moved");
   chk_last_inverse: assert property (o_stage3_out_n == !o_stage3_out)
      else $error("inverse wrong");
   chk_inverse_tracks: assert property ($changed(o_stage3_out) |-> $changed(o_stage3_out_n))
      else $error("inverse lagged");
endmodule : fsr_shift_reg_checker
bind fsr_shift_reg fsr_shift_reg_checker chk (.i_clk, .i_reset, .i_async_clear_n, .i_op_valid, .o_op_ready,
   .i_shift_load, .i_serial_j, .i_serial_k_n, .i_par_data, .o_stage0_out, .o_stage1_out, .o_stage2_out,
   .o_stage3_out, .o_stage3_out_n);
`default_nettype wire

// ===== tb/fsr_word_sink.sv
`timescale 1ns/1ps
`default_nettype none
module fsr_word_sink (
   input  wire logic i_clk,
   input  wire logic i_stall,
   output logic      o_ready
);
   logic [2:0] stall_cnt = 3'h0;
   // random pauses so the buffer fills and refuses; a stall gives way after four
   // cycles so that a request held against a full buffer always drains
   initial o_ready = 1'b0;
   always @(posedge i_clk) begin
      stall_cnt <= (i_stall && !stall_cnt[2]) ? stall_cnt + 3'h1 : 3'h0;
      o_ready   <= #1 (!i_stall || stall_cnt[2]) && $urandom_range(0, 1);
   end
endmodule : fsr_word_sink
`default_nettype wire

// ===== tb/fsr_shift_reg_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fsr_shift_reg_bench;
   logic       clk = 0, rst = 1, clr_n = 1, vld = 0, sl = 0, j = 0, kn = 0, stall = 0;
   logic [3:0] d = 4'h0, exp_q = 4'h0;
   logic [6:0] r;
   logic [3:0] wq[$];
   wire        ordy, rdy, wv, n;
   wire  [3:0] q, wd;
   int         error_cnt = 0, checks = 0;
   always #5 clk = ~clk;
   fsr_shift_reg dut (.i_clk(clk), .i_reset(rst), .i_async_clear_n(clr_n), .i_op_valid(vld), .o_op_ready(ordy),
      .i_shift_load(sl), .i_serial_j(j), .i_serial_k_n(kn), .i_par_data(d), .o_stage0_out(q[0]),
      .o_stage1_out(q[1]), .o_stage2_out(q[2]), .o_stage3_out(q[3]), .o_stage3_out_n(n),
      .o_word_valid(wv), .i_word_ready(rdy), .o_word_data(wd));
   fsr_word_sink sink (.i_clk(clk), .i_stall(stall), .o_ready(rdy));
   task automatic cmp(input string nm, input logic [4:0] e, input logic [4:0] s);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : cmp
   function automatic logic [3:0] nxt(input logic [3:0] c);
      return sl ? {c[2:0], j & ~c[0] | kn & c[0]} : d;
   endfunction : nxt
   task automatic op(input logic s, input logic jj, input logic kk, input logic [3:0] dd);
      {vld, sl, j, kn, d} = {1'b1, s, jj, kk, dd};
      do @(posedge clk); while (!ordy);
      exp_q = nxt(exp_q);
      wq.push_back(exp_q);
      #1 cmp("stages", {~exp_q[3], exp_q}, {n, q});
      cmp("word valid", 5'h01, {4'h0, wv});
   endtask : op
   task automatic end_sim;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_sim
   task automatic rst_seq;
      {vld, rst} = 2'b01;
      repeat (3) @(posedge clk);
      #1 rst = 0;
      exp_q = 4'h0;
      wq.delete();
      cmp("reset", 5'h10, {n, q});
   endtask : rst_seq
   // op checks word valid after each edge and the word order shows the rest of the buffer, so every pop is checked
   always @(posedge clk) if (wv && rdy && !rst && clr_n) cmp("word", {1'b0, wq.pop_front()}, {1'b0, wd});
   initial begin
      #50000 error_cnt++;
      end_sim();
   end
   initial begin
      void'($urandom(32'h28B41EC2));
      rst_seq();
      op(0, 1, 0, 4'h5);
      for (int c = 0; c < 4; c++) op(1, c[1], c[0], 4'hF);
      $display("codes done");
      {vld, clr_n} = 2'b00;
      #2 cmp("clear", 5'h10, {n, q});
      cmp("clear valid", 5'h00, {4'h0, wv});
      @(posedge clk);
      #1 clr_n = 1;
      {exp_q, stall} = 5'h01;
      wq.delete();
      $display("clear done");
      fork
         repeat (4) op(1, 1, 0, 4'h0);
         begin repeat (7) @(posedge clk); #1 stall = 0; end
      join
      $display("stall done");
      repeat (300) begin
         r = $urandom;
         stall = r[5] & r[4];
         op(r[0], r[1], r[2], r[6:3]);
      end
      $display("random done");
      rst_seq();
      op(0, 0, 0, 4'h9);
      $display("reset done");
      end_sim();
   end
endmodule : fsr_shift_reg_bench
`default_nettype wire
